// file: src/asle_pkg.sv
package asle_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WL_ERR_HALF_MS = 200;
  localparam int unsigned WL_LINK_HALF_MS = 150;
  localparam int unsigned MP_OFF_HALF_MS = 500;
  localparam int unsigned WARN_HALF_MS = 500;
  localparam int unsigned WL_ERR_HALF_CYC = WL_ERR_HALF_MS * CYC_PER_MS;
  localparam int unsigned WL_LINK_HALF_CYC = WL_LINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned MP_OFF_HALF_CYC = MP_OFF_HALF_MS * CYC_PER_MS;
  localparam int unsigned WARN_HALF_CYC = WARN_HALF_MS * CYC_PER_MS;
  localparam int CNT_W = 25;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic green;
    logic red;
  } asle_bicolor_s;

  typedef struct packed {
    logic critical;
    logic overheat;
    logic board_temp;
    logic overvolt;
    logic regen;
    logic fan_fail;
    logic undervolt;
  } asle_fault_s;

  typedef struct packed {
    logic fan;
    logic cap;
    logic relay;
  } asle_warn_s;

  // Code lamps: bit 0 first, bit 1 second, bit 2 third
  localparam logic [2:0] CODE_UNDERVOLT = 3'h1;
  localparam logic [2:0] CODE_FAN_FAIL = 3'h2;
  localparam logic [2:0] CODE_REGEN = 3'h4;
  localparam logic [2:0] CODE_OVERVOLT = 3'h3;
  localparam logic [2:0] CODE_BOARD_TEMP = 3'h5;
  localparam logic [2:0] CODE_OVERHEAT = 3'h6;
  localparam logic [2:0] CODE_ALL = 3'h7;

  localparam asle_bicolor_s LAMP_BOTH = '{green: 1'b1, red: 1'b1};
  localparam asle_bicolor_s LAMP_DARK = '{green: 1'b0, red: 1'b0};

endpackage

// file: src/asle_blink.sv
`timescale 1ns/1ps
module asle_blink #(
  parameter int unsigned HALF = 10
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  output logic blink_o
);

  typedef struct packed {
    logic [asle_pkg::CNT_W-1:0] cnt;
    logic blink;
  } asle_blink_st_s;

  // Cut to the counter width on purpose; HALF always fits the counter
  localparam int unsigned LAST_I = HALF - 1;
  localparam logic [asle_pkg::CNT_W-1:0] LAST = LAST_I[asle_pkg::CNT_W-1:0];

  asle_blink_st_s st_ff;
  asle_blink_st_s nxt_st;

  // Equal on and off halves of HALF cycles each
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.cnt == LAST) begin
      nxt_st.cnt = '0;
      nxt_st.blink = ~st_ff.blink;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign blink_o = st_ff.blink;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_half_period: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $changed(st_ff.blink) |-> $past(st_ff.cnt) == LAST)
    else $error("blink toggled off its half period");

endmodule

// file: src/asle_lamp_encoder.sv
`timescale 1ns/1ps
module asle_lamp_encoder #(
  parameter int unsigned MP_OFF_HALF = asle_pkg::MP_OFF_HALF_CYC,
  parameter int unsigned WL_ERR_HALF = asle_pkg::WL_ERR_HALF_CYC,
  parameter int unsigned WL_LINK_HALF = asle_pkg::WL_LINK_HALF_CYC,
  parameter int unsigned WARN_HALF = asle_pkg::WARN_HALF_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic init_i,
  input wire logic motor_power_on_i,
  input wire logic wl_connected_i,
  input wire logic wl_hw_error_i,
  input wire asle_pkg::asle_warn_s warn_i,
  input wire asle_pkg::asle_fault_s fault_i,
  output asle_pkg::asle_bicolor_s motor_supply_lamp_o,
  output asle_pkg::asle_bicolor_s wireless_lamp_o,
  output logic fault_lamp_o,
  output logic code_lamp_first_o,
  output logic code_lamp_second_o,
  output logic code_lamp_third_o,
  output logic fault_output_o,
  output logic drive_power_on_o
);

  typedef struct packed {
    asle_pkg::asle_bicolor_s mp;
    asle_pkg::asle_bicolor_s wl;
    logic fault_lamp;
    logic [2:0] code;
    logic fault_out;
    logic drive_on;
  } asle_st_s;

  // Power-on reset shows the initialising pattern with drive off
  localparam asle_st_s RST_ST = '{
    mp: asle_pkg::LAMP_BOTH,
    wl: asle_pkg::LAMP_BOTH,
    fault_lamp: 1'b1,
    code: asle_pkg::CODE_ALL,
    fault_out: 1'b0,
    drive_on: 1'b0
  };

  asle_st_s st_ff;
  asle_st_s nxt_st;
  logic mp_blink;
  logic err_blink;
  logic link_blink;
  logic warn_blink;
  logic any_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Blink sources, free running so lamps share phase

  asle_blink #(.HALF(MP_OFF_HALF)) u_mp_blink (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .blink_o(mp_blink)
  );

  asle_blink #(.HALF(WL_ERR_HALF)) u_err_blink (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .blink_o(err_blink)
  );

  asle_blink #(.HALF(WL_LINK_HALF)) u_link_blink (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .blink_o(link_blink)
  );

  asle_blink #(.HALF(WARN_HALF)) u_warn_blink (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .blink_o(warn_blink)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign any_fault = |fault_i;

  always_comb begin
    nxt_st = st_ff;
    if (init_i) begin
      nxt_st.mp = asle_pkg::LAMP_BOTH;
      nxt_st.wl = asle_pkg::LAMP_BOTH;
      nxt_st.fault_lamp = 1'b1;
      nxt_st.code = asle_pkg::CODE_ALL;
      nxt_st.fault_out = 1'b0;
      nxt_st.drive_on = 1'b0;
    end else begin
      nxt_st.mp.green = motor_power_on_i | mp_blink;
      nxt_st.mp.red = 1'b0;
      if (wl_hw_error_i) begin
        nxt_st.wl.green = 1'b0;
        nxt_st.wl.red = err_blink;
      end else if (wl_connected_i) begin
        nxt_st.wl.green = link_blink;
        nxt_st.wl.red = 1'b0;
      end else begin
        nxt_st.wl = asle_pkg::LAMP_DARK;
      end
      // Break contact opens on any fault
      nxt_st.fault_out = ~any_fault;
      nxt_st.fault_lamp = any_fault;
      // Undervoltage alone keeps drive power; the rest cut it
      nxt_st.drive_on = ~|(fault_i & ~7'h01);
      // Most severe fault wins when several are present
      if (fault_i.critical) begin
        nxt_st.code = asle_pkg::CODE_ALL;
      end else if (fault_i.overheat) begin
        nxt_st.code = asle_pkg::CODE_OVERHEAT;
      end else if (fault_i.board_temp) begin
        nxt_st.code = asle_pkg::CODE_BOARD_TEMP;
      end else if (fault_i.overvolt) begin
        nxt_st.code = asle_pkg::CODE_OVERVOLT;
      end else if (fault_i.regen) begin
        nxt_st.code = asle_pkg::CODE_REGEN;
      end else if (fault_i.fan_fail) begin
        nxt_st.code = asle_pkg::CODE_FAN_FAIL;
      end else if (fault_i.undervolt) begin
        nxt_st.code = asle_pkg::CODE_UNDERVOLT;
      end else begin
        nxt_st.code = warn_i & {3{warn_blink}};
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign motor_supply_lamp_o = st_ff.mp;
  assign wireless_lamp_o = st_ff.wl;
  assign fault_lamp_o = st_ff.fault_lamp;
  assign code_lamp_first_o = st_ff.code[0];
  assign code_lamp_second_o = st_ff.code[1];
  assign code_lamp_third_o = st_ff.code[2];
  assign fault_output_o = st_ff.fault_out;
  assign drive_power_on_o = st_ff.drive_on;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_fault_out_state: assert property (!init_i |=>
    fault_output_o == !$past(any_fault))
    else $error("fault output does not follow fault state");

  a_mp_steady_green: assert property (!init_i && motor_power_on_i |=>
    motor_supply_lamp_o == 2'b10)
    else $error("motor lamp not steady green");

  a_mp_blink_green: assert property (!init_i && !motor_power_on_i |=>
    motor_supply_lamp_o.green == $past(mp_blink)
    && !motor_supply_lamp_o.red)
    else $error("motor lamp not blinking green");

  a_init_lamps_lit: assert property (init_i |=>
    motor_supply_lamp_o == 2'b11 && wireless_lamp_o == 2'b11)
    else $error("init lamp pattern wrong");

  a_wl_idle_dark: assert property (!init_i && !wl_hw_error_i
    && !wl_connected_i |=> wireless_lamp_o == 2'b00)
    else $error("wireless lamp not dark");

  a_wl_err_red: assert property (!init_i && wl_hw_error_i |=>
    !wireless_lamp_o.green && wireless_lamp_o.red == $past(err_blink))
    else $error("wireless error blink wrong");

  a_wl_link_green: assert property (!init_i && !wl_hw_error_i
    && wl_connected_i |=> !wireless_lamp_o.red
    && wireless_lamp_o.green == $past(link_blink))
    else $error("wireless link blink wrong");

  a_warn_codes: assert property (!init_i && !any_fault |=> !fault_lamp_o
    && drive_power_on_o && fault_output_o
    && {code_lamp_third_o, code_lamp_second_o, code_lamp_first_o}
    == ($past(warn_i) & {3{$past(warn_blink)}}))
    else $error("warning code lamps wrong");

  a_undervolt_code: assert property (!init_i && fault_i == 7'h01 |=>
    fault_lamp_o && code_lamp_first_o && !code_lamp_second_o
    && !code_lamp_third_o && !fault_output_o && drive_power_on_o)
    else $error("undervoltage pattern wrong");

  a_cut_faults: assert property (!init_i && (fault_i & ~7'h01) != 7'h00
    |=> fault_lamp_o && !drive_power_on_o && !fault_output_o)
    else $error("fault did not cut drive power");

  a_board_temp_code: assert property (!init_i && fault_i == 7'h10 |=>
    {code_lamp_third_o, code_lamp_second_o, code_lamp_first_o}
    == asle_pkg::CODE_BOARD_TEMP)
    else $error("board temperature code wrong");

  a_critical_code: assert property (!init_i && fault_i.critical |=>
    {code_lamp_third_o, code_lamp_second_o, code_lamp_first_o}
    == asle_pkg::CODE_ALL)
    else $error("critical code wrong");

  a_init_code: assert property (init_i [*2] |=> fault_lamp_o
    && code_lamp_first_o && code_lamp_second_o && code_lamp_third_o
    && !fault_output_o)
    else $error("supply init pattern wrong");

  c_init_to_run: cover property (init_i ##1 !init_i && motor_power_on_i);
  c_multi_warn: cover property (!init_i && !any_fault && warn_i == 3'h7
    && warn_blink);
  c_wl_error: cover property (!init_i && wl_hw_error_i && err_blink);
  c_cut_fault: cover property (!init_i && fault_i.regen);

endmodule

// file: tb/asle_plc_model.sv
`timescale 1ns/1ps
module asle_plc_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic fault_output_i,
  output logic healthy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // break contact sampling
  // An open contact reads as a fault, so a dead line is never healthy
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      healthy_o <= 1'b0;
    end else begin
      healthy_o <= fault_output_i;
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic init_i = 1'b1;
  logic motor_power_on_i = 1'b0;
  logic wl_connected_i = 1'b0;
  logic wl_hw_error_i = 1'b0;
  asle_pkg::asle_warn_s warn_i = '0;
  asle_pkg::asle_fault_s fault_i = '0;
  asle_pkg::asle_bicolor_s mp_lamp, wl_lamp;
  logic f_lamp, c1, c2, c3, f_out, drive, plc_ok;
  logic [9:0] stat;
  logic [7:0] mon;
  int miscompares = 0;
  int comparisons = 0;
  // Small halves keep the run short; link half stays below error half
  asle_lamp_encoder #(.MP_OFF_HALF(8), .WL_ERR_HALF(10), .WL_LINK_HALF(6),
    .WARN_HALF(12)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .init_i(init_i), .motor_power_on_i(motor_power_on_i),
    .wl_connected_i(wl_connected_i), .wl_hw_error_i(wl_hw_error_i),
    .warn_i(warn_i), .fault_i(fault_i), .motor_supply_lamp_o(mp_lamp),
    .wireless_lamp_o(wl_lamp), .fault_lamp_o(f_lamp),
    .code_lamp_first_o(c1), .code_lamp_second_o(c2),
    .code_lamp_third_o(c3), .fault_output_o(f_out),
    .drive_power_on_o(drive));
  asle_plc_model plc (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .fault_output_i(f_out), .healthy_o(plc_ok));
  assign stat = {mp_lamp, wl_lamp, f_lamp, c3, c2, c1, f_out, drive};
  assign mon = {mp_lamp.red, f_lamp, c3, c2, c1, wl_lamp.red, wl_lamp.green,
    mp_lamp.green};
  always #10 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [9:0] exp,
    input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apply(input logic ini, input logic mp, input logic con,
    input logic err, input logic [2:0] w, input logic [6:0] f);
    @(posedge clock_i);
    init_i <= ini;
    motor_power_on_i <= mp;
    wl_connected_i <= con;
    wl_hw_error_i <= err;
    warn_i <= w;
    fault_i <= f;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // Length of one lit phase of a monitored lamp
  task automatic blink(input int idx, input int half);
    int n = 0;
    while (mon[idx] !== 1'b0 && n < 4 * half) begin
      @(negedge clock_i);
      n++;
    end
    while (mon[idx] !== 1'b1 && n < 8 * half) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 8 * half) begin
      miscompares++;
      close_out();
    end
    n = 0;
    while (mon[idx] === 1'b1 && n < 4 * half) begin
      @(negedge clock_i);
      n++;
    end
    chk("lit half length", 10'(half), 10'(n));
  endtask
  task automatic dark(input int idx, input int len);
    int c = 0;
    repeat (len) begin
      @(negedge clock_i);
      if (mon[idx] !== 1'b0) c++;
    end
    chk("cycles lit", 10'h000, 10'(c));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    repeat (3) @(negedge clock_i);
    chk("reset pattern", 10'h3FC, stat);
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    apply(1'b1, 1'b1, 1'b1, 1'b0, 3'h7, 7'h00);
    chk("init pattern", 10'h3FC, stat);
    chk("plc view", 10'h000, {9'h000, plc_ok});
  endtask
  task automatic t_motor();
    apply(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 7'h00);
    chk("motor on", 10'h203, stat);
    chk("plc view", 10'h001, {9'h000, plc_ok});
    apply(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 7'h00);
    blink(0, 8);
    dark(7, 40);
  endtask
  task automatic t_wireless();
    apply(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 7'h00);
    blink(1, 6);
    dark(2, 30);
    apply(1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 7'h00);
    blink(2, 10);
    dark(1, 50);
  endtask
  task automatic t_warn();
    for (int i = 0; i < 3; i++) begin
      apply(1'b0, 1'b1, 1'b0, 1'b0, 3'(1 << i), 7'h00);
      blink(3 + i, 12);
      dark(3 + ((i + 1) % 3), 30);
      dark(6, 10);
      chk("out and drive", 10'h003, {8'h00, f_out, drive});
    end
    apply(1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 7'h00);
    blink(3, 12);
    repeat (30) begin
      @(negedge clock_i);
      chk("codes together", {7'h00, {3{c1}}}, {7'h00, c3, c2, c1});
    end
  endtask
  task automatic t_faults();
    logic [2:0] codes [7];
    codes = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 7; i++) begin
      apply(1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 7'(1 << i));
      chk("fault pattern", {5'h11, codes[i], 1'b0, i == 0},
        stat);
      chk("plc view", 10'h000, {9'h000, plc_ok});
    end
  endtask
  initial begin
    t_init();
    t_motor();
    t_wireless();
    t_warn();
    t_faults();
    close_out();
  end
endmodule
